// ===== dcer_pkg.sv
// Package of constants for the disk controller error and run logic.
package dcer_pkg;
  // Clock rate in kHz, so that microsecond figures convert exactly.
  localparam int ClkKhz = 250000;
  // Timing figures as printed: select settle in tenths of a microsecond, the others in microseconds or milliseconds.
  localparam int SelectSettleTenthsUs = 15;
  localparam int RunHoldUs = 5;
  localparam int ReadSettleUs = 200;
  localparam int MissedXferMs = 130;
  // Cycle counts derived from the figures; least times round up.
  localparam int SelectSettleCycles = (SelectSettleTenthsUs * (ClkKhz / 1000) + 9) / 10;
  localparam int RunHoldCycles = RunHoldUs * (ClkKhz / 1000);
  localparam int ReadSettleCycles = ReadSettleUs * (ClkKhz / 1000);
  localparam longint MissedXferCycles = longint'(MissedXferMs) * longint'(ClkKhz);
  // Register offsets on the software port.
  localparam logic [3:0] AddrControl = 4'h0;
  localparam logic [3:0] AddrErrors = 4'h1;
  localparam logic [3:0] AddrStatus = 4'h2;
  // Counter widths.
  localparam int TimerWidth = 16;
  localparam int MissWidth = 26;
  // Run-state machine.
  typedef enum logic [1:0] {
    DCER_IDLE = 2'b00,
    DCER_RUN = 2'b01,
    DCER_HOLD = 2'b11
  } dcer_run_e;
endpackage

// ===== dcer_timer.sv
// Retriggerable down-counter: busy for a fixed number of cycles after a trigger.
`timescale 1ns/1ps
`default_nettype none
module dcer_timer #(
  parameter int Width = 16
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst,
  // Control.
  input wire logic trigger,
  input wire logic [Width-1:0] loadValue,
  // Status.
  output logic running
);
  logic [Width-1:0] count;

  // Trigger reloads the count; it then runs down to zero.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      count <= '0;
    end else if (trigger) begin
      count <= loadValue;
    end else if (count != '0) begin
      count <= count - 1'b1;
    end
  end

  assign running = (count != '0);
endmodule
`default_nettype wire

// ===== dcer_core.sv
// Error flags, interrupt request, track-run and read-disable logic of the disk controller.
`timescale 1ns/1ps
`default_nettype none
module dcer_core (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst,
  // Register port.
  input wire logic [3:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regRdData,
  // Drive pins, not synchronous to the controller.
  input wire logic timingTrackOkPin,
  input wire logic timingTrackErrPin,
  input wire logic writeLockoutPin,
  input wire logic selectErrorPin,
  // Controller timing and datapath (same clock).
  input wire logic cyclePulseOne,
  input wire logic cyclePulseTwo,
  input wire logic cyclePulseThree,
  input wire logic shiftLoadTime,
  input wire logic shiftBit17,
  input wire logic diskBit,
  input wire logic addressBit,
  input wire logic addressBitValid,
  input wire logic dataParityLeft,
  input wire logic readWordValid,
  input wire logic writeCheckLatch,
  input wire logic wantBufferToShift,
  input wire logic shiftToBufferStrobe,
  input wire logic channelEnable,
  input wire logic readBufferFull,
  input wire logic wordCountOverflow,
  input wire logic addressMatchRaw,
  input wire logic programSelect,
  input wire logic diskAddressTopCarry,
  input wire logic trackAddressCarry,
  input wire logic trackAddressClear,
  input wire logic diskRegisterClear,
  input wire logic illegalInstruction,
  input wire logic controllerClearLevel,
  // Flags to the controller.
  output logic bufferToShiftStrobe,
  output logic addressMatch,
  output logic readDisable,
  output logic timingTestEnable,
  output logic trackAddressIncrement,
  output logic diskAddressIncrement,
  output logic freezeCondition,
  output logic nonexistentDiskError,
  output logic transferComplete,
  output logic programInterrupt,
  output logic priorityInterrupt
);
  import dcer_pkg::*;

  // ******************************************************
  // Register offsets and control register
  // ******************************************************
  logic busy;
  logic interruptEnable;
  logic usePriority;
  logic maintenanceMode;
  logic opRead;
  logic opWrite;
  logic opWriteCheck;
  logic validFunction;

  // Software steers the function, busy and interrupt routing here.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      {maintenanceMode, usePriority, interruptEnable, busy} <= 4'h0;
      {opWriteCheck, opWrite, opRead} <= 3'h0;
    end else if (regWrite && regAddr == AddrControl) begin
      {maintenanceMode, usePriority, interruptEnable, busy} <= regWrData[3:0];
      {opWriteCheck, opWrite, opRead} <= regWrData[6:4];
    end
  end
  assign validFunction = opRead | opWrite | opWriteCheck;

  // ******************************************************
  // Pin synchronisers
  // ******************************************************
  logic [3:0] pinMeta;
  logic [3:0] pinSync;
  logic timingTrackOk;
  logic timingTrackErr;
  logic writeLockout;
  logic selectError;

  // Two flops before any logic reads a drive pin.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pinMeta <= 4'h0;
      pinSync <= 4'h0;
    end else begin
      pinMeta <= {selectErrorPin, writeLockoutPin, timingTrackErrPin, timingTrackOkPin};
      pinSync <= pinMeta;
    end
  end
  // Maintenance forces timing ok, since simulated tracks are too slow.
  assign timingTrackOk = pinSync[0] | maintenanceMode;
  assign timingTrackErr = pinSync[1] & ~maintenanceMode;
  assign writeLockout = pinSync[2];
  assign selectError = pinSync[3];

  // ******************************************************
  // Track running and timing-test hold
  // ******************************************************
  dcer_run_e runState;
  logic trackRunning;
  logic holdRunning;

  // Sets on pulse three with a valid function; drops when timing ok drops.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      runState <= DCER_IDLE;
    end else begin
      unique case (runState)
        DCER_IDLE: begin
          if (validFunction && timingTrackOk && cyclePulseThree) begin
            runState <= DCER_RUN;
          end
        end
        DCER_RUN: begin
          if (!timingTrackOk) begin
            runState <= DCER_HOLD;
          end
        end
        DCER_HOLD: begin
          if (!holdRunning) begin
            runState <= DCER_IDLE;
          end
        end
        default: runState <= DCER_IDLE;
      endcase
    end
  end
  assign trackRunning = (runState == DCER_RUN);

  // Hold timer restarts while running, so it lasts 5 us past the drop.
  dcer_timer #(.Width(TimerWidth)) holdTimer (
    .clk_sys(clk_sys),
    .rst(rst),
    .trigger(trackRunning),
    .loadValue(TimerWidth'(RunHoldCycles)),
    .running(holdRunning)
  );
  assign timingTestEnable = trackRunning | (runState == DCER_HOLD);
  assign addressMatch = addressMatchRaw & trackRunning;

  // ******************************************************
  // Gap handling
  // ******************************************************
  // Loss of timing in the gap steps the track; a carry requests the next disk.
  assign trackAddressIncrement = trackRunning & ~timingTrackOk;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      diskAddressIncrement <= 1'b0;
    end else if (trackAddressCarry) begin
      diskAddressIncrement <= 1'b1;
    end else if (trackRunning && busy) begin
      diskAddressIncrement <= 1'b0;
    end
  end

  // ******************************************************
  // Read disable
  // ******************************************************
  logic settleTrigger;
  logic settleRunning;
  assign settleTrigger = trackAddressIncrement | trackAddressClear | bufferToShiftStrobe
                       | diskRegisterClear;
  dcer_timer #(.Width(TimerWidth)) settleTimer (
    .clk_sys(clk_sys),
    .rst(rst),
    .trigger(settleTrigger),
    .loadValue(TimerWidth'(ReadSettleCycles)),
    .running(settleRunning)
  );
  assign readDisable = settleRunning & ~maintenanceMode;

  // ******************************************************
  // Address parity tracker
  // ******************************************************
  logic addressParityTracker;
  // Running parity toggles on each one bit; flag left set means odd.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      addressParityTracker <= 1'b0;
    end else if (cyclePulseThree || trackRunning) begin
      addressParityTracker <= 1'b0;
    end else if (addressBitValid && addressBit) begin
      addressParityTracker <= ~addressParityTracker;
    end
  end

  // ******************************************************
  // Error flags
  // ******************************************************
  logic writeCheckError;
  logic addressParityError;
  logic dataParityError;
  logic writeLockoutError;
  logic programSelectError;
  logic sequenceError;
  logic missedTransferError;
  logic channelTimingError;
  logic stopFlag;
  logic programErrorFlag;
  logic timingError;
  logic combinedError;

  // Sticky flags; set wins over the clear level.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      writeCheckError <= 1'b0;
    end else if (opWriteCheck && shiftLoadTime && shiftBit17 != diskBit) begin
      writeCheckError <= 1'b1;
    end else if (controllerClearLevel) begin
      writeCheckError <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      timingError <= 1'b0;
    end else if (timingTestEnable && timingTrackErr) begin
      timingError <= 1'b1;
    end else if (controllerClearLevel) begin
      timingError <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      addressParityError <= 1'b0;
    end else if (cyclePulseTwo && addressParityTracker) begin
      addressParityError <= 1'b1;
    end else if (controllerClearLevel) begin
      addressParityError <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      dataParityError <= 1'b0;
    end else if (cyclePulseTwo && dataParityLeft && opRead
                 && (readWordValid || writeCheckLatch)) begin
      dataParityError <= 1'b1;
    end else if (controllerClearLevel) begin
      dataParityError <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      writeLockoutError <= 1'b0;
    end else if (cyclePulseTwo && writeLockout && opWrite
                 && !dataParityError && !addressParityError) begin
      writeLockoutError <= 1'b1;
    end else if (controllerClearLevel) begin
      writeLockoutError <= 1'b0;
    end
  end
  // Lockout stops the write before the shift register is ever loaded.
  assign bufferToShiftStrobe = wantBufferToShift & ~writeLockout & ~writeLockoutError;

  // Program select waits for selection logic to settle before sampling.
  logic selectSettling;
  logic selectPending;
  dcer_timer #(.Width(TimerWidth)) selectTimer (
    .clk_sys(clk_sys),
    .rst(rst),
    .trigger(programSelect),
    .loadValue(TimerWidth'(SelectSettleCycles)),
    .running(selectSettling)
  );
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      selectPending <= 1'b0;
    end else if (programSelect) begin
      selectPending <= 1'b1;
    end else if (!selectSettling) begin
      selectPending <= 1'b0;
    end
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      programSelectError <= 1'b0;
    end else if (selectPending && !selectSettling && !programSelect && selectError) begin
      programSelectError <= 1'b1;
    end else if (controllerClearLevel) begin
      programSelectError <= 1'b0;
    end
  end

  // Delayed increment request, gated with busy and buffer not full.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sequenceError <= 1'b0;
    end else if (diskAddressIncrement && busy && !readBufferFull
                 && (selectError || diskAddressTopCarry)) begin
      sequenceError <= 1'b1;
    end else if (controllerClearLevel) begin
      sequenceError <= 1'b0;
    end
  end
  assign nonexistentDiskError = programSelectError | sequenceError;

  // Missed transfer: busy too long with no channel enable.
  logic [MissWidth-1:0] missCount;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      missCount <= '0;
    end else if (!busy || channelEnable) begin
      missCount <= '0;
    end else if (missCount != MissWidth'(MissedXferCycles)) begin
      missCount <= missCount + 1'b1;
    end
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      missedTransferError <= 1'b0;
    end else if (missCount == MissWidth'(MissedXferCycles)) begin
      missedTransferError <= 1'b1;
    end else if (controllerClearLevel) begin
      missedTransferError <= 1'b0;
    end
  end

  // Watches arm at pulse one; the proper strobe must clear them by pulse three.
  logic readTimingWatch;
  logic loadTimingWatch;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      readTimingWatch <= 1'b0;
      loadTimingWatch <= 1'b0;
    end else begin
      if (cyclePulseOne && opRead && !opWriteCheck) begin
        readTimingWatch <= 1'b1;
      end else if (shiftToBufferStrobe || cyclePulseThree) begin
        readTimingWatch <= 1'b0;
      end
      if (cyclePulseOne && (opWrite || opWriteCheck)) begin
        loadTimingWatch <= 1'b1;
      end else if (bufferToShiftStrobe || cyclePulseThree) begin
        loadTimingWatch <= 1'b0;
      end
    end
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      channelTimingError <= 1'b0;
    end else if (cyclePulseThree && readTimingWatch && !shiftToBufferStrobe) begin
      channelTimingError <= 1'b1;
    end else if (cyclePulseThree && loadTimingWatch && !bufferToShiftStrobe) begin
      channelTimingError <= 1'b1;
    end else if (controllerClearLevel) begin
      channelTimingError <= 1'b0;
    end
  end

  // Stop latches an illegal instruction while busy and sets program error.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      stopFlag <= 1'b0;
      programErrorFlag <= 1'b0;
    end else begin
      if (illegalInstruction && busy) begin
        stopFlag <= 1'b1;
      end else if (controllerClearLevel) begin
        stopFlag <= 1'b0;
      end
      if (stopFlag) begin
        programErrorFlag <= 1'b1;
      end else if (controllerClearLevel) begin
        programErrorFlag <= 1'b0;
      end
    end
  end

  assign freezeCondition = timingError | addressParityError;
  assign combinedError = writeCheckError | timingError | addressParityError | dataParityError
                       | writeLockoutError | nonexistentDiskError | missedTransferError
                       | channelTimingError | programErrorFlag;

  // ******************************************************
  // Interrupt request
  // ******************************************************
  logic interruptRequest;
  // Busy gating makes a write finish its last word before completion shows.
  assign transferComplete = wordCountOverflow & ~busy;
  assign interruptRequest = interruptEnable & (transferComplete | combinedError);
  assign programInterrupt = interruptRequest & ~usePriority;
  assign priorityInterrupt = interruptRequest & usePriority;

  // ******************************************************
  // Read port
  // ******************************************************
  // Unmapped offsets read as zero; data stand only in the cycle after the strobe.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      regRdData <= 32'h0;
    end else if (regRead) begin
      unique case (regAddr)
        AddrControl: regRdData <= {25'h0, opWriteCheck, opWrite, opRead, maintenanceMode,
                                   usePriority, interruptEnable, busy};
        AddrErrors: regRdData <= {21'h0, combinedError, programErrorFlag, channelTimingError,
                                  missedTransferError, sequenceError, programSelectError,
                                  writeLockoutError, dataParityError, addressParityError,
                                  writeCheckError, timingError};
        AddrStatus: regRdData <= {26'h0, readDisable, freezeCondition, transferComplete,
                                  diskAddressIncrement, timingTestEnable, trackRunning};
        default: regRdData <= 32'h0;
      endcase
    end else begin
      regRdData <= 32'h0;
    end
  end
endmodule
`default_nettype wire

// ===== dcer_core_sva.sv
// Port checker for the disk controller error and run logic.
`timescale 1ns/1ps
`default_nettype none
module dcer_core_sva (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst,
  // Watched inputs.
  input wire logic regRead,
  input wire logic writeLockoutPin,
  input wire logic wantBufferToShift,
  input wire logic addressMatchRaw,
  input wire logic wordCountOverflow,
  input wire logic programSelect,
  input wire logic diskAddressTopCarry,
  input wire logic trackAddressCarry,
  // Watched outputs.
  input wire logic [31:0] regRdData,
  input wire logic bufferToShiftStrobe,
  input wire logic addressMatch,
  input wire logic readDisable,
  input wire logic timingTestEnable,
  input wire logic diskAddressIncrement,
  input wire logic nonexistentDiskError,
  input wire logic transferComplete,
  input wire logic programInterrupt,
  input wire logic priorityInterrupt
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // The lockout pin passes a two-flop synchroniser before it can block anything.
  sequence lockHeld;
    writeLockoutPin [*3];
  endsequence
  sequence quietSelect;
    programSelect && !nonexistentDiskError && !diskAddressTopCarry;
  endsequence
  a_strobe_needs_want: assert property (bufferToShiftStrobe |-> wantBufferToShift)
    else $error("transfer strobe without a request");
  a_lockout_blocks_strobe: assert property (lockHeld |-> !bufferToShiftStrobe)
    else $error("transfer strobe under write lockout");
  a_match_needs_raw: assert property (addressMatch |-> addressMatchRaw)
    else $error("address match without a raw match");
  a_match_under_test: assert property (addressMatch |-> timingTestEnable)
    else $error("address match while the timing test is off");
  a_irq_one_kind: assert property (!(programInterrupt && priorityInterrupt))
    else $error("both interrupt kinds at once");
  a_done_needs_ovf: assert property (transferComplete |-> wordCountOverflow)
    else $error("completion without word count overflow");
  a_rdata_after_read: assert property (regRdData != 32'h0 |-> $past(regRead))
    else $error("read data outside the answer cycle");
  a_disk_inc_cause: assert property ($rose(diskAddressIncrement) |-> $past(trackAddressCarry))
    else $error("disk increment without track carry");
  a_select_settles: assert property (quietSelect |=> !nonexistentDiskError [*8])
    else $error("select error before the settle time");
  a_readdis_holds: assert property ($rose(readDisable) |=> readDisable [*8])
    else $error("read disable too short");
endmodule
bind dcer_core dcer_core_sva chk (.clk_sys, .rst, .regRead, .writeLockoutPin, .wantBufferToShift,
  .addressMatchRaw, .wordCountOverflow, .programSelect, .diskAddressTopCarry, .trackAddressCarry,
  .regRdData, .bufferToShiftStrobe, .addressMatch, .readDisable, .timingTestEnable,
  .diskAddressIncrement, .nonexistentDiskError, .transferComplete, .programInterrupt,
  .priorityInterrupt);
`default_nettype wire

// ===== dcer_disk_model.sv
// Timing-track model of the drive: cycle pulses one, two and three in a fixed rotation.
`timescale 1ns/1ps
`default_nettype none
module dcer_disk_model #(
  parameter int Period = 12
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst,
  // Control.
  input wire logic spin,
  // Cycle pulses.
  output logic pulseOne,
  output logic pulseTwo,
  output logic pulseThree
);
  logic [3:0] phase;
  // Word-cell phase; it stands still while the disk is not spinning.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      phase <= 4'h0;
    end else if (spin) begin
      phase <= (phase == 4'(Period - 1)) ? 4'h0 : phase + 4'h1;
    end
  end
  // Pulse two sits between one and three, inside each watch window from pulse one to pulse three.
  assign pulseOne = spin && (phase == 4'h0);
  assign pulseTwo = spin && (phase == 4'h4);
  assign pulseThree = spin && (phase == 4'h8);
endmodule
`default_nettype wire

// ===== dcer_core_tb.sv
// Self-checking bench of the disk controller error and run logic.
`timescale 1ns/1ps
`default_nettype none
module dcer_core_tb;
  // ************
  // Signals
  // ************
  logic clk_sys = 1'b0, rst = 1'b1, regWrite = 1'b0, regRead = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [31:0] regWrData = 32'h0, regRdData;
  logic timingTrackOkPin = 0, timingTrackErrPin = 0, writeLockoutPin = 0, selectErrorPin = 0;
  logic tbPulseTwo = 0, shiftLoadTime = 0, shiftBit17 = 0, diskBit = 0, addressBit = 0;
  logic addressBitValid = 0, dataParityLeft = 0, readWordValid = 0, writeCheckLatch = 0;
  logic wantBufferToShift = 0, shiftToBufferStrobe = 0, channelEnable = 0, readBufferFull = 0;
  logic wordCountOverflow = 0, addressMatchRaw = 0, programSelect = 0, diskAddressTopCarry = 0;
  logic trackAddressCarry = 0, trackAddressClear = 0, diskRegisterClear = 0, spin = 0;
  logic illegalInstruction = 0, controllerClearLevel = 0, mOne, mTwo, mThree;
  logic bufferToShiftStrobe, addressMatch, readDisable, timingTestEnable, trackAddressIncrement;
  logic diskAddressIncrement, freezeCondition, nonexistentDiskError, transferComplete;
  logic programInterrupt, priorityInterrupt;
  int numErrors = 0, samplesChecked = 0;
  dcer_disk_model disk (.clk_sys, .rst, .spin, .pulseOne(mOne), .pulseTwo(mTwo),
    .pulseThree(mThree));
  dcer_core DUT (.clk_sys, .rst, .regAddr, .regWrData, .regWrite, .regRead, .regRdData,
    .timingTrackOkPin, .timingTrackErrPin, .writeLockoutPin, .selectErrorPin,
    .cyclePulseOne(mOne), .cyclePulseTwo(mTwo | tbPulseTwo), .cyclePulseThree(mThree),
    .shiftLoadTime, .shiftBit17, .diskBit, .addressBit, .addressBitValid, .dataParityLeft,
    .readWordValid, .writeCheckLatch, .wantBufferToShift, .shiftToBufferStrobe, .channelEnable,
    .readBufferFull, .wordCountOverflow, .addressMatchRaw, .programSelect, .diskAddressTopCarry,
    .trackAddressCarry, .trackAddressClear, .diskRegisterClear, .illegalInstruction,
    .controllerClearLevel, .bufferToShiftStrobe, .addressMatch, .readDisable, .timingTestEnable,
    .trackAddressIncrement, .diskAddressIncrement, .freezeCondition, .nonexistentDiskError,
    .transferComplete, .programInterrupt, .priorityInterrupt);
  // ************
  // Tasks
  // ************
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // Register values are compared with case equality so an unknown never matches.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      numErrors++;
      $display("BAD t=%0t register %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chkFlag(input logic got, input logic exp);
    samplesChecked++;
    if (got !== exp) begin
      numErrors++;
      $display("BAD t=%0t flag %b expected %b", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge clk_sys);
    regWrite <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so they are sampled there.
  task automatic rd(input logic [3:0] a, input logic [31:0] exp, input logic [31:0] m);
    @(posedge clk_sys);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk_sys);
    regRead <= 1'b0;
    #1;
    chk(regRdData & m, exp);
  endtask
  task automatic clr;
    @(posedge clk_sys) controllerClearLevel <= 1'b1;
    @(posedge clk_sys) controllerClearLevel <= 1'b0;
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", samplesChecked, numErrors);
    if (numErrors == 0 && samplesChecked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Clock of 4 ns and a watchdog far beyond the few thousand cycles the tests need.
  initial forever #2 clk_sys = ~clk_sys;
  initial begin
    #200000;
    numErrors++;
    complete_run;
  end
  // ************
  // Tests
  // ************
  initial begin
    step(5);
    rst <= 1'b0;
    rd(4'h1, 32'h0, 32'hffffffff);
    rd(4'hf, 32'h0, 32'hffffffff);
    wr(4'h0, 32'h41);
    shiftBit17 <= 1'b1;
    @(posedge clk_sys) shiftLoadTime <= 1'b1;
    @(posedge clk_sys) shiftLoadTime <= 1'b0;
    rd(4'h1, 32'h402, 32'h402);
    wr(4'h0, 32'h43);
    step(2);
    #1;
    chk(32'({priorityInterrupt, programInterrupt}), 32'h1);
    wr(4'h0, 32'h47);
    step(2);
    #1;
    chk(32'({priorityInterrupt, programInterrupt}), 32'h2);
    wr(4'h0, 32'h41);
    step(2);
    #1;
    chk(32'({priorityInterrupt, programInterrupt}), 32'h0);
    clr;
    rd(4'h1, 32'h0, 32'hffffffff);
    @(posedge clk_sys) illegalInstruction <= 1'b1;
    @(posedge clk_sys) illegalInstruction <= 1'b0;
    rd(4'h1, 32'h600, 32'h600);
    clr;
    // A track carry raises the disk step request that the stepping error needs.
    @(posedge clk_sys) trackAddressCarry <= 1'b1;
    @(posedge clk_sys) trackAddressCarry <= 1'b0;
    // A full read buffer means the last word was taken, so no stepping error.
    readBufferFull <= 1'b1;
    @(posedge clk_sys) diskAddressTopCarry <= 1'b1;
    @(posedge clk_sys) diskAddressTopCarry <= 1'b0;
    step(400);
    rd(4'h1, 32'h0, 32'h40);
    readBufferFull <= 1'b0;
    @(posedge clk_sys) diskAddressTopCarry <= 1'b1;
    @(posedge clk_sys) diskAddressTopCarry <= 1'b0;
    step(400);
    rd(4'h1, 32'h440, 32'h440);
    chkFlag(nonexistentDiskError, 1'b1);
    clr;
    wr(4'h0, 32'h0);
    selectErrorPin <= 1'b1;
    @(posedge clk_sys) programSelect <= 1'b1;
    @(posedge clk_sys) programSelect <= 1'b0;
    step(349);
    #1;
    chkFlag(nonexistentDiskError, 1'b0);
    step(50);
    #1;
    chkFlag(nonexistentDiskError, 1'b1);
    rd(4'h1, 32'h20, 32'h60);
    selectErrorPin <= 1'b0;
    clr;
    wr(4'h0, 32'h11);
    @(posedge clk_sys) trackAddressCarry <= 1'b1;
    @(posedge clk_sys) trackAddressCarry <= 1'b0;
    step(1);
    #1;
    chkFlag(diskAddressIncrement, 1'b1);
    timingTrackOkPin <= 1'b1;
    addressMatchRaw <= 1'b1;
    spin <= 1'b1;
    step(40);
    rd(4'h2, 32'h3, 32'h23);
    chkFlag(addressMatch, 1'b1);
    chkFlag(diskAddressIncrement, 1'b0);
    rd(4'h1, 32'h500, 32'h500);
    timingTrackOkPin <= 1'b0;
    step(6);
    rd(4'h2, 32'h22, 32'h23);
    chkFlag(addressMatch, 1'b0);
    timingTrackErrPin <= 1'b1;
    step(4);
    #1;
    chkFlag(freezeCondition, 1'b1);
    timingTrackErrPin <= 1'b0;
    step(1300);
    rd(4'h2, 32'h0, 32'h2);
    spin <= 1'b0;
    addressMatchRaw <= 1'b0;
    clr;
    wr(4'h0, 32'h1);
    wordCountOverflow <= 1'b1;
    step(2);
    #1;
    chkFlag(transferComplete, 1'b0);
    wr(4'h0, 32'h0);
    step(2);
    #1;
    chkFlag(transferComplete, 1'b1);
    wordCountOverflow <= 1'b0;
    // Odd address bits and a leftover data bit, then a second address one restores parity.
    wr(4'h0, 32'h11);
    addressBit <= 1'b1;
    dataParityLeft <= 1'b1;
    readWordValid <= 1'b1;
    @(posedge clk_sys) addressBitValid <= 1'b1;
    @(posedge clk_sys) addressBitValid <= 1'b0;
    @(posedge clk_sys) tbPulseTwo <= 1'b1;
    @(posedge clk_sys) tbPulseTwo <= 1'b0;
    rd(4'h1, 32'h40c, 32'h40c);
    chkFlag(freezeCondition, 1'b1);
    @(posedge clk_sys) addressBitValid <= 1'b1;
    @(posedge clk_sys) addressBitValid <= 1'b0;
    dataParityLeft <= 1'b0;
    clr;
    step(1);
    #1;
    chkFlag(freezeCondition, 1'b0);
    wr(4'h0, 32'h21);
    wantBufferToShift <= 1'b1;
    step(3);
    #1;
    chkFlag(bufferToShiftStrobe, 1'b1);
    writeLockoutPin <= 1'b1;
    step(4);
    #1;
    chkFlag(bufferToShiftStrobe, 1'b0);
    @(posedge clk_sys) tbPulseTwo <= 1'b1;
    @(posedge clk_sys) tbPulseTwo <= 1'b0;
    rd(4'h1, 32'h10, 32'h1c);
    @(posedge clk_sys) trackAddressClear <= 1'b1;
    @(posedge clk_sys) trackAddressClear <= 1'b0;
    step(3);
    #1;
    chkFlag(readDisable, 1'b1);
    complete_run;
  end
endmodule
`default_nettype wire
